/* File: verilog/gcm_pkg.sv */
// gcm_pkg: shared constants and types for the global clock driver bank.
// assumes one 200 MHz system clock and a plain strobe register port.
package gcm_pkg;

  localparam int GCM_NUM_CELLS = 16;
  localparam int GCM_ADDR_W    = 8;
  localparam int GCM_DATA_W    = 32;

  // register map, byte addresses
  localparam logic [7:0] GCM_CFG_BASE  = 8'h00;
  localparam logic [7:0] GCM_CFG_SPAN  = 8'h40;
  localparam logic [7:0] GCM_SEL_STAT  = 8'h40;
  localparam logic [7:0] GCM_BUSY_STAT = 8'h44;
  localparam logic [7:0] GCM_LOCK      = 8'h48;

  // per-cell config word layout
  localparam int GCM_IDX_LSB   = 2;
  localparam int GCM_IDX_W     = 4;
  localparam int GCM_CFG_W     = 3;
  localparam int GCM_MODE_LSB  = 0;
  localparam int GCM_MODE_W    = 2;
  localparam int GCM_FALL_BIT  = 2;
  localparam int GCM_LOCK_BIT  = 0;

  localparam logic [2:0] GCM_CFG_RST = 3'h0;
  localparam logic [1:0] GCM_ALIGN   = 2'h0;

  typedef enum logic [1:0] {
    GCM_MODE_OFF  = 2'b00,
    GCM_MODE_BUF  = 2'b01,
    GCM_MODE_GATE = 2'b10,
    GCM_MODE_MUX  = 2'b11
  } gcm_mode_e;

  typedef enum logic [1:0] {
    GCM_SW_RUN   = 2'b00,
    GCM_SW_DRAIN = 2'b01,
    GCM_SW_PARK  = 2'b10
  } gcm_sw_e;

endpackage : gcm_pkg

/* File: verilog/gcm_gate_cell.sv */
// gcm_gate_cell: whole-pulse clock gate working on sampled clock levels.
// assumes levels are already normalised to rising-edge sense by the caller.
`timescale 1ns/10ps
module gcm_gate_cell
  import gcm_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic restart,
  input  wire logic src_now,
  input  wire logic src_prev,
  input  wire logic enable_prev,
  output logic      gate_level
);

  logic gate_open_reg;
  logic rise;

  assign rise = src_now & ~src_prev;

  // decision taken only at the rising edge, from the level before it
  always_ff @(posedge clk) begin
    if (srst || restart) begin
      gate_open_reg <= 1'b0;
    end else if (rise) begin
      gate_open_reg <= enable_prev;
    end
  end

  // full high phase passes or output stays low for the whole pulse
  assign gate_level = src_now & (rise ? enable_prev : gate_open_reg);

endmodule : gcm_gate_cell

/* File: verilog/gcm_clock_bank.sv */
// gcm_clock_bank: bank of global clock drivers with gate, mux and buffer modes.
// assumes clock sources, enables and selects are synchronous to clk and
// sampled at 200 MHz; registers reached over a plain strobe port.
//
// Overview of operation
// - enabled before rise, whole pulse passes
// - enable changes during high phase ignored
// - disabled before rise, pulse suppressed, output low
// - select low picks source a, high b
// - sources may be unrelated or asynchronous
// - no glitch or short phase on switchover
// - select ignored while current clock high
// - park low until new clock falls
// - edge sense fixed by configuration
// - falling sense inverts clocks, not controls
// - buffer mode forwards clock unchanged
// - sixteen independent driver cells
// - unused branches keep running; off mode holds output low
`timescale 1ns/10ps
module gcm_clock_bank
  import gcm_pkg::*;
#(
  parameter int NUM_CELLS = GCM_NUM_CELLS
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [GCM_ADDR_W-1:0] reg_addr,
  input  wire logic [GCM_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [GCM_DATA_W-1:0] reg_rdata,
  input  wire logic [NUM_CELLS-1:0]  clock_source_a,
  input  wire logic [NUM_CELLS-1:0]  clock_source_b,
  input  wire logic [NUM_CELLS-1:0]  gate_enable,
  input  wire logic [NUM_CELLS-1:0]  clock_select,
  output logic      [NUM_CELLS-1:0]  clk_out,
  output logic      [NUM_CELLS-1:0]  active_sel
);

  logic [GCM_CFG_W-1:0]  cfg_reg [NUM_CELLS];
  logic                  lock_reg;
  logic [GCM_DATA_W-1:0] rdata_reg;
  logic [NUM_CELLS-1:0]  busy;
  logic [GCM_IDX_W-1:0]  idx;
  logic                  cfg_hit;
  logic                  cfg_wr;

  // address decode
  assign idx     = reg_addr[GCM_IDX_LSB +: GCM_IDX_W];
  assign cfg_hit = (reg_addr < GCM_CFG_SPAN) && (reg_addr[1:0] == GCM_ALIGN)
                   && (32'(idx) < NUM_CELLS);
  assign cfg_wr  = reg_wr && cfg_hit && !lock_reg;

  // configuration words, frozen once locked
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int k = 0; k < NUM_CELLS; k++) begin
        cfg_reg[k] <= GCM_CFG_RST;
      end
    end else if (cfg_wr) begin
      cfg_reg[idx] <= reg_wdata[GCM_CFG_W-1:0];
    end
  end

  // lock bit, cleared only by reset
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_reg <= 1'b0;
    end else if (reg_wr && reg_addr == GCM_LOCK && reg_wdata[GCM_LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      if (cfg_hit) begin
        rdata_reg <= {{(GCM_DATA_W-GCM_CFG_W){1'b0}}, cfg_reg[idx]};
      end else if (reg_addr == GCM_SEL_STAT) begin
        rdata_reg <= {{(GCM_DATA_W-NUM_CELLS){1'b0}}, active_sel};
      end else if (reg_addr == GCM_BUSY_STAT) begin
        rdata_reg <= {{(GCM_DATA_W-NUM_CELLS){1'b0}}, busy};
      end else if (reg_addr == GCM_LOCK) begin
        rdata_reg <= {{(GCM_DATA_W-1){1'b0}}, lock_reg};
      end else begin
        rdata_reg <= '0;
      end
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata = rdata_reg;

  // one driver cell per global line
  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    gcm_mode_e  mode;
    logic       fall;
    logic       restart;
    logic       a_n;
    logic       b_n;
    logic       a_prev_reg;
    logic       b_prev_reg;
    logic       en_prev_reg;
    logic       sel_prev_reg;
    logic       a_fall;
    logic       b_fall;
    logic       cur_n;
    logic       cur_prev;
    logic       tgt_fall;
    gcm_sw_e    sw_reg;
    logic       cur_sel_reg;
    logic       mux_level;
    logic       gate_level;
    logic       out_next;
    logic       out_reg;

    assign mode    = gcm_mode_e'(cfg_reg[i][GCM_MODE_LSB +: GCM_MODE_W]);
    assign fall    = cfg_reg[i][GCM_FALL_BIT];
    assign restart = cfg_wr && (idx == GCM_IDX_W'(i));

    // falling sense: clock levels inverted, controls untouched
    assign a_n = clock_source_a[i] ^ fall;
    assign b_n = clock_source_b[i] ^ fall;

    // previous levels for edge detection and before-edge control
    always_ff @(posedge clk) begin
      if (srst) begin
        a_prev_reg   <= 1'b0;
        b_prev_reg   <= 1'b0;
        en_prev_reg  <= 1'b0;
        sel_prev_reg <= 1'b0;
      end else begin
        a_prev_reg   <= a_n;
        b_prev_reg   <= b_n;
        en_prev_reg  <= gate_enable[i];
        sel_prev_reg <= clock_select[i];
      end
    end

    assign a_fall   = ~a_n & a_prev_reg;
    assign b_fall   = ~b_n & b_prev_reg;
    assign cur_n    = cur_sel_reg ? b_n : a_n;
    assign cur_prev = cur_sel_reg ? b_prev_reg : a_prev_reg;
    assign tgt_fall = sel_prev_reg ? b_fall : a_fall;

    // switchover sequencer, starts parked with output low
    always_ff @(posedge clk) begin
      if (srst || restart) begin
        sw_reg      <= GCM_SW_PARK;
        cur_sel_reg <= 1'b0;
      end else begin
        case (sw_reg)
          GCM_SW_RUN: begin
            if (sel_prev_reg != cur_sel_reg) begin
              if (cur_n || (cur_prev && !cur_n)) begin
                sw_reg <= cur_n ? GCM_SW_DRAIN : GCM_SW_PARK;
              end else begin
                sw_reg <= GCM_SW_PARK;
              end
            end
          end
          GCM_SW_DRAIN: begin
            if (!cur_n) begin
              sw_reg <= GCM_SW_PARK;
            end
          end
          GCM_SW_PARK: begin
            if (tgt_fall) begin
              cur_sel_reg <= sel_prev_reg;
              sw_reg      <= GCM_SW_RUN;
            end
          end
          default: begin
            sw_reg <= GCM_SW_PARK;
          end
        endcase
      end
    end

    // forward current clock, or hold low while parked
    always_comb begin
      case (sw_reg)
        GCM_SW_RUN:   mux_level = cur_n;
        GCM_SW_DRAIN: mux_level = cur_n;
        GCM_SW_PARK:  mux_level = 1'b0;
        default:      mux_level = 1'b0;
      endcase
    end

    gcm_gate_cell u_gate (
      .clk         (clk),
      .srst        (srst),
      .restart     (restart),
      .src_now     (a_n),
      .src_prev    (a_prev_reg),
      .enable_prev (en_prev_reg),
      .gate_level  (gate_level)
    );

    // mode select and polarity restore
    always_comb begin
      case (mode)
        GCM_MODE_OFF:  out_next = 1'b0;
        GCM_MODE_BUF:  out_next = clock_source_a[i];
        GCM_MODE_GATE: out_next = gate_level ^ fall;
        GCM_MODE_MUX:  out_next = mux_level ^ fall;
        default:       out_next = 1'b0;
      endcase
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        out_reg <= 1'b0;
      end else begin
        out_reg <= out_next;
      end
    end

    assign clk_out[i]    = out_reg;
    assign active_sel[i] = cur_sel_reg;
    assign busy[i]       = (sw_reg != GCM_SW_RUN);
  end

endmodule : gcm_clock_bank

/* File: verif/gcm_bank_chk_sva.sv */
// checker: port relations of the clock bank, watched cell 2
// assumes binding into gcm_clock_bank, one clk domain
`timescale 1ns/10ps
module gcm_bank_chk
  import gcm_pkg::*;
#(
  parameter int NUM_CELLS = GCM_NUM_CELLS
) (
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic                 reg_wr,
  input wire logic [NUM_CELLS-1:0] clock_source_a,
  input wire logic [NUM_CELLS-1:0] clock_source_b,
  input wire logic [NUM_CELLS-1:0] clock_select,
  input wire logic [NUM_CELLS-1:0] clk_out,
  input wire logic [NUM_CELLS-1:0] active_sel
);
  logic [3:0] ha_reg;
  logic [3:0] hb_reg;
  logic [3:0] hs_reg;
  logic [3:0] hw_reg;
  always_ff @(posedge clk) begin
    ha_reg <= {ha_reg[2:0], clock_source_a[2]};
    hb_reg <= {hb_reg[2:0], clock_source_b[2]};
    hs_reg <= {hs_reg[2:0], clock_select[2]};
    hw_reg <= {hw_reg[2:0], reg_wr};
  end
  wire mv_a = |ha_reg && !(&ha_reg);
  wire mv_b = |hb_reg && !(&hb_reg);
  wire mv_w = |hw_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rst;
    disable iff (1'b0) srst |=> !clk_out && !active_sel;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left outputs");
  property p_start;
    $fell(srst) |=> !clk_out;
  endproperty
  a_start: assert property (p_start) else $error("output high at start");
  property p_cause;
    $changed(clk_out[2]) |-> mv_a || mv_b || mv_w;
  endproperty
  a_cause: assert property (p_cause) else $error("output moved alone");
  property p_rise_b;
    $rose(active_sel[2]) |-> mv_b;
  endproperty
  a_rise_b: assert property (p_rise_b) else $error("switch without b edge");
  property p_rise_s;
    $rose(active_sel[2]) |-> |hs_reg;
  endproperty
  a_rise_s: assert property (p_rise_s) else $error("b taken unselected");
  property p_fall_a;
    $fell(active_sel[2]) |-> mv_a || mv_w;
  endproperty
  a_fall_a: assert property (p_fall_a) else $error("switch without a edge");
  property p_fall_s;
    $fell(active_sel[2]) |-> !(&hs_reg) || mv_w;
  endproperty
  a_fall_s: assert property (p_fall_s) else $error("a taken unselected");
  property p_quiet;
    $changed(active_sel[2]) |-> $stable(clk_out[2]) || mv_w;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output moved at switch");
endmodule : gcm_bank_chk
bind gcm_clock_bank gcm_bank_chk #(.NUM_CELLS(NUM_CELLS)) chk (
  .clk(clk), .srst(srst), .reg_wr(reg_wr), .clock_source_a(clock_source_a),
  .clock_source_b(clock_source_b), .clock_select(clock_select),
  .clk_out(clk_out), .active_sel(active_sel));

/* File: verif/gcm_fabric_src.sv */
// fabric model: two unrelated clock sources per cell
// assumes sampled-level clocks in the clk domain
`timescale 1ns/10ps
module gcm_fabric_src (
  input  wire logic        clk,
  input  wire logic        slow,
  output logic      [15:0] src_a,
  output logic      [15:0] src_b
);
  logic [4:0] cnt_a_reg = 5'h00;
  logic [4:0] cnt_b_reg = 5'h00;
  always_ff @(posedge clk) cnt_a_reg <= cnt_a_reg + 5'h01;
  always_ff @(posedge clk) cnt_b_reg <= cnt_b_reg + (slow ? 5'h01 : 5'h03);
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      src_a[i] = cnt_a_reg[i % 4];
      src_b[i] = cnt_b_reg[(i % 4) + int'(slow)];
    end
  end
endmodule : gcm_fabric_src

/* File: verif/tb.sv */
// testbench: off, buffer, gate, falling gate and mux modes
// assumes fabric model drives sources; reset held 6 clocks
`timescale 1ns/10ps
module tb import gcm_pkg::*;;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [15:0] en = 16'h0;
  logic [15:0] sel = 16'h0;
  logic [15:0] a, b, co, asel, a1, a2, b1, cp, e1, e2;
  int          err_total = 0;
  int          n_checks = 0;
  int          seed = 40;
  int          m = 0;
  initial forever #2.5 clk = ~clk;
  gcm_fabric_src src (.clk(clk), .slow(slow), .src_a(a), .src_b(b));
  gcm_clock_bank uut (.clk(clk), .srst(srst), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .clock_source_a(a),
    .clock_source_b(b), .gate_enable(en), .clock_select(sel), .clk_out(co),
    .active_sel(asel));
  always @(posedge clk) begin
    a1 <= a;
    a2 <= a1;
    b1 <= b;
    cp <= co;
    e1 <= en;
    e2 <= e1;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(rdat, exp);
  endtask : rreg
  task automatic cfg(input logic [2:0] v);
    for (int i = 0; i < 16; i++) wreg(8'(4 * i), {29'h0, v});
  endtask : cfg
  task automatic run(input int mm, input int n);
    @(posedge clk);
    m = mm;
    repeat (n) @(posedge clk);
    m = 0;
  endtask : run
  always @(negedge clk) begin
    if (m == 1) cmp({16'h0, co}, 32'h0);
    if (m == 2) cmp({16'h0, co}, {16'h0, a1});
    if (m == 3) cmp({16'h0, co & ~a1 | (co ^ cp) & a1 & a2}, 32'h0);
    if (m == 3) cmp({16'h0, co & a1 & ~a2}, {16'h0, e2 & a1 & ~a2});
    if (m == 4) cmp({co, asel}, {sel & b1 | ~sel & a1, sel});
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) rreg(8'(4 * i), 32'h0);
    run(1, 100);
    cfg(3'h1);
    run(0, 4);
    run(2, 200);
    cfg(3'h2);
    en <= 16'hFFFF;
    run(0, 40);
    run(2, 200);
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      en <= 16'($random(seed));
      m = 3;
    end
    en <= 16'h0;
    run(0, 40);
    run(1, 200);
    cfg(3'h6);
    en <= 16'hFFFF;
    run(0, 40);
    run(2, 200);
    srst <= 1'b1;
    run(0, 2);
    srst <= 1'b0;
    rreg(8'h08, 32'h0);
    cfg(3'h3);
    for (int k = 0; k < 8; k++) begin
      slow <= k[0];
      sel <= (k == 7) ? 16'hFFFF : 16'($random(seed));
      run(0, 60);
      run(4, 100);
    end
    wreg(GCM_LOCK, 32'h1);
    wreg(8'h00, 32'h1);
    rreg(8'h00, 32'h3);
    rreg(GCM_SEL_STAT, 32'h0000FFFF);
    rreg(GCM_BUSY_STAT, 32'h0);
    rreg(8'h80, 32'h0);
    complete_run();
  end
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule : tb
